// file: hdl/anps_pkg.sv
// constants and types shared by the next-page and expansion status block
package anps_pkg;

  // ----------------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------------
  localparam int unsigned DATA_W = 32;        // bus data width
  localparam int unsigned REG_W  = 16;        // management register width
  localparam int unsigned IDX_W  = 8;         // register index width
  localparam int unsigned EVT_N  = 3;         // number of interrupt events

  // ----------------------------------------------------------------------
  // register indices; byte address is four times the index
  // ----------------------------------------------------------------------
  localparam logic [IDX_W-1:0] IDX_PAGE    = 8'h05; // partner next page
  localparam logic [IDX_W-1:0] IDX_EXP     = 8'h06; // expansion status
  localparam logic [IDX_W-1:0] IDX_IRQ_ST  = 8'h08; // sticky status, ro
  localparam logic [IDX_W-1:0] IDX_IRQ_CLR = 8'h09; // clear, wo
  localparam logic [IDX_W-1:0] IDX_IRQ_EN  = 8'h0A; // enable, rw

  // ----------------------------------------------------------------------
  // field positions of the partner next-page word
  // ----------------------------------------------------------------------
  localparam int unsigned PG_ACK_BIT   = 14;  // partner acknowledge
  localparam int unsigned PG_FMT_BIT   = 13;  // formatted_page_flag
  localparam int unsigned PG_CMPLY_BIT = 12;  // comply_acknowledge_flag
  localparam int unsigned PG_TOG_BIT   = 11;  // toggle
  localparam int unsigned PG_CODE_MSB  = 10;  // code field 10:0

  // ----------------------------------------------------------------------
  // field positions of the expansion status word
  // ----------------------------------------------------------------------
  localparam int unsigned EXP_RSV_LSB  = 5;   // 15:5 reserved
  localparam int unsigned EXP_PDF_BIT  = 4;   // parallel_detect_fault
  localparam int unsigned EXP_LPNP_BIT = 3;   // partner_next_page_capable
  localparam int unsigned EXP_NP_BIT   = 2;   // local_next_page_capable
  localparam int unsigned EXP_RX_BIT   = 1;   // page received, cor
  localparam int unsigned EXP_LPAN_BIT = 0;   // partner_autoneg_capable

  // ----------------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------------
  localparam logic [REG_W-1:0] PAGE_RST   = 16'h0000;
  localparam logic             FLAG_RST   = 1'b0;
  localparam logic             NP_CAPABLE = 1'b1;   // fixed one
  localparam logic [EVT_N-1:0] IRQ_EN_RST = 3'h0;

  // ----------------------------------------------------------------------
  // interrupt event positions
  // ----------------------------------------------------------------------
  localparam int unsigned EVT_PAGE = 0;       // page received
  localparam int unsigned EVT_PDF  = 1;       // fault rose
  localparam int unsigned EVT_LPAN = 2;       // partner autoneg rose

  // ----------------------------------------------------------------------
  // bus data-phase state, gray along idle -> write / idle -> read
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    ANPS_PH_IDLE = 2'b00,
    ANPS_PH_WR   = 2'b01,
    ANPS_PH_RD   = 2'b10
  } anps_phase_t;

endpackage

// file: hdl/anps_evt_if.sv
// interface between the top and the sticky interrupt status bank
`timescale 1ns/1ps
interface anps_evt_if;
  logic [anps_pkg::EVT_N-1:0] evt;   // one-cycle event pulses
  logic [anps_pkg::EVT_N-1:0] clr;   // one-cycle clear pulses
  logic [anps_pkg::EVT_N-1:0] st;    // sticky status bits

  modport ctrl (output evt, output clr, input st);
  modport bank (input evt, input clr, output st);
endinterface

// file: hdl/anps_evt_bank.sv
// sticky interrupt status bits, one per event
`timescale 1ns/1ps
module anps_evt_bank (
  input  wire logic clk,
  input  wire logic reset,
  anps_evt_if.bank  eb
);
  // ----------------------------------------------------------------------
  // per-bit sticky flag
  // ----------------------------------------------------------------------
  for (genvar i = 0; i < anps_pkg::EVT_N; i++) begin : g_bit
    logic st_r;
    // set wins over a clear in the same cycle, so no event is lost
    always_ff @(posedge clk) begin
      if (reset) begin
        st_r <= anps_pkg::FLAG_RST;
      end else begin
        st_r <= eb.evt[i] | (st_r & ~eb.clr[i]);
      end
    end
    assign eb.st[i] = st_r;
  end
endmodule

// file: hdl/anps_page_cap.sv
// holding register for the partner next-page word
`timescale 1ns/1ps
module anps_page_cap #(
  parameter int unsigned W = anps_pkg::REG_W
) (
  input  wire logic         clk,
  input  wire logic         reset,
  input  wire logic         load,
  input  wire logic [W-1:0] word_in,
  output logic      [W-1:0] word_out
);
  // ----------------------------------------------------------------------
  // whole-word capture
  // ----------------------------------------------------------------------
  logic [W-1:0] word_r;   // last page received

  // every field loads on the same edge: no mixed old and new view
  always_ff @(posedge clk) begin
    if (reset) begin
      word_r <= anps_pkg::PAGE_RST;
    end else if (load) begin
      word_r <= word_in;  // RULE15
    end
  end

  assign word_out = word_r;
endmodule

// file: hdl/anps_top.sv
// next-page and expansion status registers behind an ahb-lite slave
//
// The AHB-Lite register port was left to the implementer.
`timescale 1ns/1ps

// Contract
// (RULE1) bit 13 flags formatted message page
// (RULE2) bit 12 shows partner can comply
// (RULE3) bit 11 shows partner toggle bit
// (RULE4) bits 10:0 hold partner code, reset zero
// (RULE5) expansion register at 0x06, read-only
// (RULE6) expansion bits 15:5 read zero
// (RULE7) bit 4 shows parallel detection fault
// (RULE8) bit 3 shows partner next-page ability
// (RULE9) bit 2 reads fixed one
// (RULE10) bit 1 sets on page, clears on read
// (RULE11) bit 0 shows partner autoneg ability
// (RULE12) partner next-page word at 0x05
// (RULE13) acknowledge bit updated only by engine
// (RULE14) new page beats same-cycle read clear
// (RULE15) page fields captured together per word
module anps_top #(
  parameter int unsigned ADDR_W = 32       // bus address width
) (
  input  wire logic                         clk,
  input  wire logic                         reset,
  input  wire logic                         hsel,
  input  wire logic [ADDR_W-1:0]            haddr,
  input  wire logic [1:0]                   htrans,
  input  wire logic                         hwrite,
  input  wire logic [2:0]                   hsize,
  input  wire logic [anps_pkg::DATA_W-1:0]  hwdata,
  input  wire logic                         hready,
  output logic                              hreadyout,
  output logic [anps_pkg::DATA_W-1:0]       hrdata,
  output logic                              hresp,
  input  wire logic                         pg_valid,
  input  wire logic [anps_pkg::REG_W-1:0]   pg_word,
  input  wire logic                         pdf_in,
  input  wire logic                         lp_np_in,
  input  wire logic                         lp_an_in,
  output logic                              irq
);

  // ----------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------
  localparam int unsigned DW = anps_pkg::DATA_W;
  localparam int unsigned RW = anps_pkg::REG_W;
  localparam int unsigned EN = anps_pkg::EVT_N;
  localparam int unsigned IW = anps_pkg::IDX_W;

  anps_pkg::anps_phase_t  phase_r;        // data-phase state
  anps_pkg::anps_phase_t  phase_nxt;      // its next value
  logic [IW-1:0]          idx_r;          // latched register index
  logic                   hreadyout_r;    // wait-state flop
  logic [DW-1:0]          hrdata_r;       // read data flop
  logic                   hresp_r;        // always okay
  logic                   irq_r;          // interrupt level flop
  logic                   pdf_r;          // fault level
  logic                   lp_np_r;        // partner next-page level
  logic                   lp_an_r;        // partner autoneg level
  logic                   page_rx_r;      // page received, cor
  logic                   page_rx_nxt;    // its next value
  logic [EN-1:0]          irq_en_r;       // interrupt enables
  logic [RW-1:0]          page_word;      // held partner page
  logic [RW-1:0]          exp_word;       // assembled expansion word
  logic [DW-1:0]          rd_mux;         // selected read value

  anps_evt_if evt_if ();                  // link to sticky bank

  // ----------------------------------------------------------------------
  // address phase decode
  // ----------------------------------------------------------------------
  wire addr_take  = hsel & htrans[1] & hready & hreadyout_r;
  wire take_rd    = addr_take & ~hwrite;
  wire take_wr    = addr_take & hwrite;
  wire [IW-1:0] addr_idx = haddr[IW+1:2];

  // data phase decode
  wire in_rd      = (phase_r == anps_pkg::ANPS_PH_RD);
  wire in_wr      = (phase_r == anps_pkg::ANPS_PH_WR);
  wire hit_page   = (idx_r == anps_pkg::IDX_PAGE);    // RULE12
  wire hit_exp    = (idx_r == anps_pkg::IDX_EXP);     // RULE5
  wire hit_st     = (idx_r == anps_pkg::IDX_IRQ_ST);
  wire hit_clr    = (idx_r == anps_pkg::IDX_IRQ_CLR);
  wire hit_en     = (idx_r == anps_pkg::IDX_IRQ_EN);

  // write strobes; the two status registers take no write at all
  wire wr_clr     = in_wr & hit_clr;
  wire wr_en      = in_wr & hit_en;

  // read of the expansion register clears the page flag
  wire rd_exp     = in_rd & hit_exp;

  // ----------------------------------------------------------------------
  // bus phase state machine
  // ----------------------------------------------------------------------
  // reads take one wait state so that a write one transfer earlier
  // lands before the read samples; writes finish with no wait
  always_comb begin
    phase_nxt = anps_pkg::ANPS_PH_IDLE;
    case (phase_r)
      anps_pkg::ANPS_PH_RD: begin
        phase_nxt = anps_pkg::ANPS_PH_IDLE;   // read answers now
      end
      anps_pkg::ANPS_PH_IDLE,
      anps_pkg::ANPS_PH_WR: begin
        if (take_rd) begin
          phase_nxt = anps_pkg::ANPS_PH_RD;
        end else if (take_wr) begin
          phase_nxt = anps_pkg::ANPS_PH_WR;
        end else begin
          phase_nxt = anps_pkg::ANPS_PH_IDLE;
        end
      end
      default: begin
        phase_nxt = anps_pkg::ANPS_PH_IDLE;   // recover from bad code
      end
    endcase
  end

  // state and latched index
  always_ff @(posedge clk) begin
    if (reset) begin
      phase_r <= anps_pkg::ANPS_PH_IDLE;
      idx_r   <= '0;
    end else begin
      phase_r <= phase_nxt;
      if (addr_take) begin
        idx_r <= addr_idx;
      end
    end
  end

  // hready drops for the one cycle after a read is taken
  always_ff @(posedge clk) begin
    if (reset) begin
      hreadyout_r <= 1'b1;
    end else begin
      hreadyout_r <= ~take_rd;
    end
  end

  // response never signals an error, unmapped reads give zero
  always_ff @(posedge clk) begin
    if (reset) begin
      hresp_r <= 1'b0;
    end else begin
      hresp_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // partner page holding register
  // ----------------------------------------------------------------------
  // only the engine's valid strobe loads it; bus writes never reach it
  anps_page_cap #(
    .W        (RW)
  ) u_page (
    .clk      (clk),
    .reset    (reset),
    .load     (pg_valid),                      // RULE13
    .word_in  (pg_word),
    .word_out (page_word)
  );

  // ----------------------------------------------------------------------
  // expansion status levels
  // ----------------------------------------------------------------------
  // engine outputs share this clock, so one flop each is enough
  always_ff @(posedge clk) begin
    if (reset) begin
      pdf_r   <= anps_pkg::FLAG_RST;
      lp_np_r <= anps_pkg::FLAG_RST;
      lp_an_r <= anps_pkg::FLAG_RST;
    end else begin
      pdf_r   <= pdf_in;                       // RULE7
      lp_np_r <= lp_np_in;                     // RULE8
      lp_an_r <= lp_an_in;                     // RULE11
    end
  end

  // page flag: a new page wins over the clear from a read
  assign page_rx_nxt = pg_valid | (page_rx_r & ~rd_exp); // RULE10 RULE14

  always_ff @(posedge clk) begin
    if (reset) begin
      page_rx_r <= anps_pkg::FLAG_RST;
    end else begin
      page_rx_r <= page_rx_nxt;
    end
  end

  // reserved bits are constant zero, local ability a constant one
  assign exp_word = {
    {(RW - anps_pkg::EXP_RSV_LSB){1'b0}},      // RULE6
    pdf_r,
    lp_np_r,
    anps_pkg::NP_CAPABLE,                      // RULE9
    page_rx_r,
    lp_an_r
  };

  // ----------------------------------------------------------------------
  // interrupt events and enables
  // ----------------------------------------------------------------------
  // the fault and partner autoneg levels raise an event only on their rising edge; partner next-page raises none
  assign evt_if.evt[anps_pkg::EVT_PAGE] = pg_valid;
  assign evt_if.evt[anps_pkg::EVT_PDF]  = pdf_in & ~pdf_r;
  assign evt_if.evt[anps_pkg::EVT_LPAN] = lp_an_in & ~lp_an_r;
  assign evt_if.clr = wr_clr ? hwdata[EN-1:0] : '0;

  anps_evt_bank u_evt (
    .clk   (clk),
    .reset (reset),
    .eb    (evt_if)
  );

  // enable register, software owned
  always_ff @(posedge clk) begin
    if (reset) begin
      irq_en_r <= anps_pkg::IRQ_EN_RST;
    end else if (wr_en) begin
      irq_en_r <= hwdata[EN-1:0];
    end
  end

  // level interrupt, one cycle behind the sticky bits
  always_ff @(posedge clk) begin
    if (reset) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(evt_if.st & irq_en_r);
    end
  end

  // ----------------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------------
  assign rd_mux =
      hit_page ? {{(DW - RW){1'b0}}, page_word} :  // RULE1 RULE2 RULE3 RULE4
      hit_exp  ? {{(DW - RW){1'b0}}, exp_word}  :
      hit_st   ? {{(DW - EN){1'b0}}, evt_if.st} :
      hit_en   ? {{(DW - EN){1'b0}}, irq_en_r}  :
                 {DW{1'b0}};                     // clear reg and holes

  // data flop loads only at the end of the read wait state
  always_ff @(posedge clk) begin
    if (reset) begin
      hrdata_r <= '0;
    end else if (in_rd) begin
      hrdata_r <= rd_mux;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign hreadyout = hreadyout_r;
  assign hrdata    = hrdata_r;
  assign hresp     = hresp_r;
  assign irq       = irq_r;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  chk_fmt_flag: assert property (@(posedge clk) disable iff (reset) // RULE1
    pg_valid |=> page_word[anps_pkg::PG_FMT_BIT] ==
                 $past(pg_word[anps_pkg::PG_FMT_BIT]))
    else $error("format flag not taken from page");

  chk_comply_flag: assert property (@(posedge clk) disable iff (reset) // RULE2
    pg_valid |=> page_word[anps_pkg::PG_CMPLY_BIT] ==
                 $past(pg_word[anps_pkg::PG_CMPLY_BIT]))
    else $error("comply flag not taken from page");

  chk_toggle_bit: assert property (@(posedge clk) disable iff (reset) // RULE3
    pg_valid |=> page_word[anps_pkg::PG_TOG_BIT] ==
                 $past(pg_word[anps_pkg::PG_TOG_BIT]))
    else $error("toggle bit not taken from page");

  chk_code_field: assert property (@(posedge clk) disable iff (reset) // RULE4
    pg_valid |=> page_word[anps_pkg::PG_CODE_MSB:0] ==
                 $past(pg_word[anps_pkg::PG_CODE_MSB:0]))
    else $error("code field not taken from page");

  chk_exp_readonly: assert property (@(posedge clk) disable iff (reset) // RULE5
    (in_wr && hit_exp && !pg_valid && $stable(pdf_in) &&
     $stable(lp_np_in) && $stable(lp_an_in)) |=> $stable(exp_word))
    else $error("write changed expansion register");

  chk_rsv_zero: assert property (@(posedge clk) disable iff (reset) // RULE6
    (in_rd && hit_exp) |=> hrdata[DW-1:anps_pkg::EXP_RSV_LSB] == '0)
    else $error("reserved expansion bits not zero");

  chk_pdf_follow: assert property (@(posedge clk) disable iff (reset) // RULE7
    (in_rd && hit_exp) |=>
      hrdata[anps_pkg::EXP_PDF_BIT] == $past(pdf_r))
    else $error("fault bit does not follow input");

  chk_lpnp_follow: assert property (@(posedge clk) disable iff (reset) // RULE8
    ##1 lp_np_r == $past(lp_np_in))
    else $error("partner next page bit lags");

  chk_np_one: assert property (@(posedge clk) disable iff (reset) // RULE9
    (in_rd && hit_exp) |=> hrdata[anps_pkg::EXP_NP_BIT])
    else $error("local next page bit not one");

  chk_rx_clear: assert property (@(posedge clk) disable iff (reset) // RULE10
    (rd_exp && !pg_valid) |=> (!page_rx_r && hreadyout))
    else $error("page flag not cleared by read");

  chk_rx_set: assert property (@(posedge clk) disable iff (reset) // RULE10
    pg_valid |=> page_rx_r)
    else $error("page flag not set by page");

  chk_lpan_follow: assert property (@(posedge clk) disable iff (reset) // RULE11
    (in_rd && hit_exp) |=>
      hrdata[anps_pkg::EXP_LPAN_BIT] == $past(lp_an_r))
    else $error("autoneg bit does not follow input");

  chk_page_read: assert property (@(posedge clk) disable iff (reset) // RULE12
    (take_rd && addr_idx == anps_pkg::IDX_PAGE && !pg_valid) |=>
      !hreadyout ##1 (hreadyout && hrdata[RW-1:0] == $past(page_word)))
    else $error("page register read wrong");

  chk_ack_hold: assert property (@(posedge clk) disable iff (reset) // RULE13
    !pg_valid |=> $stable(page_word[anps_pkg::PG_ACK_BIT]))
    else $error("acknowledge changed without page");

  chk_rx_race: assert property (@(posedge clk) disable iff (reset) // RULE14
    (rd_exp && pg_valid) |=> page_rx_r)
    else $error("page lost to read clear");

  chk_word_whole: assert property (@(posedge clk) disable iff (reset) // RULE15
    !pg_valid |=> $stable(page_word))
    else $error("page word changed without page");

  // a read stalls exactly one cycle, a write none
  chk_read_wait: assert property (@(posedge clk) disable iff (reset)
    take_rd |=> !hreadyout ##1 hreadyout)
    else $error("read wait state not one cycle");

  chk_write_nowait: assert property (@(posedge clk) disable iff (reset)
    take_wr |=> hreadyout)
    else $error("write inserted a wait state");

  // first edge out of reset sees reset values
  chk_page_reset: assert property (@(posedge clk) disable iff (reset) // RULE4
    $fell(reset) |-> page_word == anps_pkg::PAGE_RST)
    else $error("page word not zero after reset");

  chk_flag_reset: assert property (@(posedge clk) disable iff (reset) // RULE7
    $fell(reset) |-> (!pdf_r && !lp_an_r && !page_rx_r))
    else $error("expansion flags not zero after reset");

  // interrupt follows enabled sticky bits one cycle later
  chk_irq_raise: assert property (@(posedge clk) disable iff (reset)
    (|(evt_if.st & irq_en_r)) |=> irq)
    else $error("enabled status did not raise interrupt");

  chk_irq_mask: assert property (@(posedge clk) disable iff (reset)
    (irq_en_r == '0) |=> !irq)
    else $error("interrupt raised while masked");

endmodule

// file: bench/anps_partner_model.sv
// behavioural auto-negotiation engine feeding pages and levels
`timescale 1ns/1ps
module anps_partner_model (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        send_req,
  input  wire logic [15:0] send_word,
  input  wire logic [2:0]  lv,
  output logic             pg_valid,
  output logic [15:0]      pg_word,
  output logic             pdf_o,
  output logic             lp_np_o,
  output logic             lp_an_o
);
  // ----
  // page pulse and link levels, launched one edge after the request
  // ----
  always_ff @(posedge clk) begin
    if (reset) begin
      pg_valid <= 1'b0;
      pg_word  <= 16'h0000;
      {pdf_o, lp_np_o, lp_an_o} <= 3'h0;
    end else begin
      pg_valid <= send_req;
      // outside a pulse the word is junk, so it flips every cycle
      pg_word  <= send_req ? send_word : ~pg_word;
      {pdf_o, lp_np_o, lp_an_o} <= lv;
    end
  end
endmodule

// file: bench/anps_top_bench.sv
// self-checking bench for the next-page and expansion status block
`timescale 1ns/1ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin err_total++; \
  $display("unexpected at %0t: got %h expected %h", $time, a, e); end end
module anps_top_bench;
  typedef struct {
    logic [15:0] word;  // page sent
    logic [2:0]  lv;    // pdf, partner np, partner an
    logic [15:0] exp;   // expansion word expected
  } anps_row_t;
  // ----
  // signals
  // ----
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic        hreadyout, hresp, irq, pg_valid, parallel_detect_fault, lp_np, lp_an;
  logic [31:0] hrdata, rd;
  logic [15:0] pg_word, send_word = 16'h0;
  logic        send_req = 1'b0;
  logic [2:0]  lv = 3'h0;
  int          err_total = 0;
  int          checked = 0;
  anps_row_t   rows[4] = '{'{16'hA7FF, 3'b000, 16'h0006},
                           '{16'h5800, 3'b111, 16'h001F},
                           '{16'h2001, 3'b101, 16'h0017},
                           '{16'h1555, 3'b010, 16'h000E}};
  always #10 clk = ~clk;  // 50 MHz
  anps_top anps_top_inst (.clk(clk), .reset(reset), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .pg_valid(pg_valid),
    .pg_word(pg_word), .pdf_in(parallel_detect_fault), .lp_np_in(lp_np),
    .lp_an_in(lp_an), .irq(irq));
  anps_partner_model anps_partner_model_inst (.clk(clk), .reset(reset),
    .send_req(send_req), .send_word(send_word), .lv(lv),
    .pg_valid(pg_valid), .pg_word(pg_word), .pdf_o(parallel_detect_fault),
    .lp_np_o(lp_np), .lp_an_o(lp_an));
  // ----
  // bus and page helpers
  // ----
  // one single transfer; inj lands a page on the read's capture edge
  task automatic bus(input logic wr, input logic [31:0] a, w,
                     output logic [31:0] r, input logic inj);
    int n;
    n = 0;
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= wr;
    send_req <= inj;
    @(posedge clk);
    send_req <= 1'b0;
    while (hreadyout !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    htrans <= 2'b00;
    hwdata <= w;
    @(posedge clk);
    while (hreadyout !== 1'b1 && n < 40) begin
      @(posedge clk);
      n++;
    end
    r = hrdata;
    `CHK(hresp, 1'b0)
    if (n >= 40) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, n, 0);
      conclude();
    end
  endtask
  // read and compare in one go
  task automatic rchk(input logic [31:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0, rd, 1'b0);
    `CHK(rd, e)
  endtask
  // page pulse, then let capture and irq settle
  task automatic page(input logic [15:0] w);
    send_req <= 1'b1;
    send_word <= w;
    @(posedge clk);
    send_req <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  task automatic conclude;
    $display("comparisons %0d, mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // ----
  // watchdog, far beyond the roughly 150 cycles of the run
  // ----
  initial begin
    repeat (5000) @(posedge clk);
    err_total++;
    conclude();
  end
  // ----
  // main sequence
  // ----
  initial begin
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    `CHK(irq, 1'b0)
    rchk(32'h14, 32'h0);
    rchk(32'h18, 32'h4);
    // table of pages and levels
    foreach (rows[i]) begin
      lv <= rows[i].lv;
      page(rows[i].word);
      rchk(32'h14, {16'h0, rows[i].word});
      rchk(32'h18, {16'h0, rows[i].exp});
      rchk(32'h18, {16'h0, rows[i].exp & 16'hFFFD});
    end
    // writes to read-only places change nothing
    bus(1'b1, 32'h18, 32'hFFFF_FFFF, rd, 1'b0);
    bus(1'b1, 32'h14, 32'hFFFF_FFFF, rd, 1'b0);
    rchk(32'h18, 32'h0000_000C);
    rchk(32'h14, 32'h0000_1555);
    rchk(32'h3C, 32'h0);
    // page landing on the read's clearing edge survives
    bus(1'b0, 32'h18, 32'h0, rd, 1'b1);
    bus(1'b0, 32'h18, 32'h0, rd, 1'b0);
    `CHK(rd[1], 1'b1)
    rchk(32'h18, 32'h0000_000C);
    // interrupt: clear, enable, raise, clear, mask
    bus(1'b1, 32'h24, 32'h7, rd, 1'b0);
    bus(1'b1, 32'h28, 32'h7, rd, 1'b0);
    rchk(32'h28, 32'h7);
    `CHK(irq, 1'b0)
    page(16'h3123);
    `CHK(irq, 1'b1)
    rchk(32'h20, 32'h1);
    rchk(32'h14, 32'h3123);
    bus(1'b1, 32'h20, 32'h0, rd, 1'b0);
    rchk(32'h20, 32'h1);
    bus(1'b1, 32'h24, 32'h1, rd, 1'b0);
    repeat (2) @(posedge clk);
    `CHK(irq, 1'b0)
    rchk(32'h24, 32'h0);
    bus(1'b1, 32'h28, 32'h0, rd, 1'b0);
    lv <= 3'b001;
    page(16'h0800);
    `CHK(irq, 1'b0)
    rchk(32'h20, 32'h5);
    rchk(32'h18, 32'h0000_0007);
    // mid-run reset drops the live interrupt and every field
    bus(1'b1, 32'h28, 32'h7, rd, 1'b0);
    repeat (2) @(posedge clk);
    `CHK(irq, 1'b1)
    lv <= 3'b000;
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    `CHK(irq, 1'b0)
    rchk(32'h14, 32'h0);
    rchk(32'h18, 32'h4);
    rchk(32'h20, 32'h0);
    rchk(32'h28, 32'h0);
    conclude();
  end
endmodule
